// *** hw/tre_pkg.sv ***
package tre_pkg;

  // register map, byte addresses
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STAT      = 8'h04;
  localparam logic [7:0]  REG_MOTION    = 8'h08;

  // control register fields
  localparam int unsigned CTRL_SEVEN    = 0;
  localparam int unsigned CTRL_FMK      = 1;
  localparam int unsigned CTRL_WRITE    = 2;
  localparam int unsigned CTRL_START    = 3;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // gap counter: loading 8 leaves the low three bits at zero
  localparam logic [3:0]  GAP_LOAD      = 4'h8;
  localparam logic [2:0]  GAP_THREE     = 3'h3;
  localparam logic [2:0]  GAP_SIX       = 3'h6;
  localparam logic [2:0]  GAP_LAST      = 3'h7;

  // decision delay: one extra unit costs 8 character clocks
  localparam logic [1:0]  DD_EXTEND     = 2'h2;
  localparam logic [1:0]  DD_RESET      = 2'h0;

  // more than two characters makes a record
  localparam logic [1:0]  STRB_RECORD   = 2'h3;

  // motion delay counter
  localparam logic [15:0] MOTION_RESET  = 16'h4000;
  localparam int unsigned MOTION_GATE   = 13;
  localparam int unsigned MOTION_B14    = 14;
  localparam int unsigned MOTION_B15    = 15;

  // prescaler: first tick after two pulses, then every four
  localparam logic [1:0]  PRESC_START   = 2'h2;

  typedef struct packed {
    logic       char_clock;
    logic       read_strobe;
    logic       slave_clock;
    logic [6:0] read_lines;
  } tre_drv_in_type;

  typedef struct packed {
    logic crc_next;
    logic lrc_next;
    logic read_data_strobe;
    logic check_register_pulse;
    logic crc_error;
    logic record_end;
    logic read_clear_pulse;
    logic stop_request;
    logic read_active;
    logic decel;
    logic motion;
    logic stop;
  } tre_out_type;

endpackage : tre_pkg

// *** hw/tre_prescaler.sv ***
`timescale 1ns/1ns
module tre_prescaler
  import tre_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic restart,
  input  wire logic pulse,
  output logic      tick
);

  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic       tick_nxt;

  assign cnt_nxt  = restart ? PRESC_START : (pulse ? cnt_r + 2'h1 : cnt_r);
  assign tick_nxt = ~restart & pulse & (cnt_r == 2'h3);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= PRESC_START;
      tick  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick  <= tick_nxt;
    end
  end

endmodule : tre_prescaler

// *** hw/tre_eor_detect.sv ***
`timescale 1ns/1ns
module tre_eor_detect
  import tre_pkg::*;
(
  input  wire logic           aclk,
  input  wire logic           aresetn,
  input  wire logic [7:0]     s_axi_awaddr,
  input  wire logic           s_axi_awvalid,
  output logic                s_axi_awready,
  input  wire logic [31:0]    s_axi_wdata,
  input  wire logic [3:0]     s_axi_wstrb,
  input  wire logic           s_axi_wvalid,
  output logic                s_axi_wready,
  output logic [1:0]          s_axi_bresp,
  output logic                s_axi_bvalid,
  input  wire logic           s_axi_bready,
  input  wire logic [7:0]     s_axi_araddr,
  input  wire logic           s_axi_arvalid,
  output logic                s_axi_arready,
  output logic [31:0]         s_axi_rdata,
  output logic [1:0]          s_axi_rresp,
  output logic                s_axi_rvalid,
  input  wire logic           s_axi_rready,
  input  wire tre_drv_in_type drive_in,
  input  wire logic           crc_nonzero,
  output tre_out_type         ctl_out
);

  function automatic logic rise(input logic now, input logic was);
    return now & ~was;
  endfunction : rise
  function automatic logic gap_hit(input logic step, input logic [3:0] gap,
                                   input logic [2:0] target);
    return step & ((gap[2:0] + 3'h1) == target);
  endfunction : gap_hit

  // pin synchronisers; first stage feeds only the second
  tre_drv_in_type sync1_r;
  tre_drv_in_type sync2_r;
  tre_drv_in_type prev_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r  <= '0;
    end else begin
      sync1_r <= drive_in;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // control and state registers
  logic        seven_track_mode_r;
  logic        filemark_mode_r;
  logic        write_active_r;
  logic        start_r;
  logic [3:0]  gap_r;
  logic [3:0]  gap_nxt;
  logic        crc_phase_r;
  logic        crc_phase_nxt;
  logic        lrc_phase_r;
  logic        lrc_phase_nxt;
  logic        record_end_r;
  logic        record_end_nxt;
  logic [1:0]  delay_r;
  logic [1:0]  delay_nxt;
  logic [1:0]  strobe_cnt_r;
  logic [1:0]  strobe_cnt_nxt;
  logic        end_r;
  logic        end_nxt;
  logic [15:0] motion_cnt_r;
  logic [15:0] motion_cnt_nxt;
  logic        motion_r;
  logic        motion_nxt;
  logic        presc_tick;

  wire drive_char_clock  = rise(sync2_r.char_clock, prev_r.char_clock);
  wire drive_read_strobe = rise(sync2_r.read_strobe, prev_r.read_strobe);
  wire slave_pulse       = rise(sync2_r.slave_clock, prev_r.slave_clock);
  wire decel_now         = ~motion_cnt_r[MOTION_B14];
  wire short_mode        = seven_track_mode_r | filemark_mode_r;
  wire in_check          = crc_phase_r | lrc_phase_r;
  wire gap_step = drive_char_clock & ~write_active_r & ~decel_now;
  wire artificial = gap_hit(gap_step, gap_r, GAP_SIX) & in_check & ~drive_read_strobe;
  wire composite_read_strobe = drive_read_strobe | artificial;
  wire check_register_pulse  = composite_read_strobe;
  wire gap_overflow          = gap_step & (gap_r[2:0] == GAP_LAST) & ~composite_read_strobe;
  wire record_active = (strobe_cnt_r == STRB_RECORD) | filemark_mode_r;
  wire gap_three = gap_hit(gap_step, gap_r, GAP_THREE) & ~composite_read_strobe;
  wire eor_go    = gap_three & record_active & ~record_end_r & ~in_check;
  wire read_clear_pulse = gap_overflow & record_end_r & (delay_r == DD_RESET) & ~end_r;

  always_comb begin
    gap_nxt = gap_r;
    if (start_r || composite_read_strobe) begin
      gap_nxt = GAP_LOAD;
    end else if (gap_step) begin
      gap_nxt = gap_r + 4'h1;
    end
  end
  always_comb begin
    crc_phase_nxt = crc_phase_r;
    if (start_r || record_end_r || lrc_phase_r) begin
      crc_phase_nxt = 1'b0;
    end else if (check_register_pulse && crc_phase_r) begin
      crc_phase_nxt = 1'b0;
    end else if (eor_go && !short_mode) begin
      crc_phase_nxt = 1'b1;
    end
  end
  always_comb begin
    lrc_phase_nxt = lrc_phase_r;
    if (start_r) begin
      lrc_phase_nxt = 1'b0;
    end else if (check_register_pulse && lrc_phase_r) begin
      lrc_phase_nxt = 1'b0;
    end else if (check_register_pulse && crc_phase_r) begin
      lrc_phase_nxt = 1'b1;
    end else if (eor_go && short_mode) begin
      lrc_phase_nxt = 1'b1;
    end
  end
  always_comb begin
    record_end_nxt = record_end_r;
    if (start_r) begin
      record_end_nxt = 1'b0;
    end else if (lrc_phase_r && !lrc_phase_nxt) begin
      record_end_nxt = 1'b1;
    end
  end
  always_comb begin
    delay_nxt = delay_r;
    if (start_r) begin
      delay_nxt = DD_RESET;
    end else if (drive_read_strobe) begin
      delay_nxt = lrc_phase_r ? DD_RESET : DD_EXTEND;
    end else if (gap_overflow && record_end_r && delay_r != DD_RESET) begin
      delay_nxt = delay_r - 2'h1;
    end
  end
  always_comb begin
    strobe_cnt_nxt = strobe_cnt_r;
    if (start_r) begin
      strobe_cnt_nxt = 2'h0;
    end else if (drive_read_strobe && strobe_cnt_r != STRB_RECORD) begin
      strobe_cnt_nxt = strobe_cnt_r + 2'h1;
    end
  end
  assign end_nxt = start_r ? 1'b0 : (end_r | read_clear_pulse);
  always_comb begin
    motion_cnt_nxt = motion_cnt_r;
    if (start_r) begin
      motion_cnt_nxt = MOTION_RESET;
    end else if (read_clear_pulse) begin
      motion_cnt_nxt = {motion_cnt_r[MOTION_B14], motion_cnt_r[MOTION_B14], 1'b1,
                        6'h00, sync2_r.read_lines};
    end else if (presc_tick && motion_cnt_r[MOTION_GATE]) begin
      motion_cnt_nxt = motion_cnt_r + 16'h0001;
    end
  end
  assign motion_nxt = start_r ? 1'b1 : (motion_r & ~decel_now);
  tre_prescaler u_presc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (read_clear_pulse),
    .pulse   (slave_pulse),
    .tick    (presc_tick)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_r        <= GAP_LOAD;
      crc_phase_r  <= 1'b0;
      lrc_phase_r  <= 1'b0;
      record_end_r <= 1'b0;
      delay_r      <= DD_RESET;
      strobe_cnt_r <= 2'h0;
      end_r        <= 1'b0;
      motion_cnt_r <= MOTION_RESET;
      motion_r     <= 1'b0;
    end else begin
      gap_r        <= gap_nxt;
      crc_phase_r  <= crc_phase_nxt;
      lrc_phase_r  <= lrc_phase_nxt;
      record_end_r <= record_end_nxt;
      delay_r      <= delay_nxt;
      strobe_cnt_r <= strobe_cnt_nxt;
      end_r        <= end_nxt;
      motion_cnt_r <= motion_cnt_nxt;
      motion_r     <= motion_nxt;
    end
  end

  // outputs registered once more so every pin comes from a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_out <= '0;
    end else begin
      ctl_out.crc_next             <= crc_phase_r;
      ctl_out.lrc_next             <= lrc_phase_r;
      ctl_out.read_data_strobe     <= composite_read_strobe;
      ctl_out.check_register_pulse <= check_register_pulse;
      ctl_out.crc_error            <= crc_phase_r & crc_nonzero;
      ctl_out.record_end           <= record_end_r;
      ctl_out.read_clear_pulse     <= read_clear_pulse;
      ctl_out.stop_request         <= end_r;
      ctl_out.read_active          <= motion_cnt_r[MOTION_B14] ^ motion_cnt_r[MOTION_B15];
      ctl_out.decel                <= decel_now;
      ctl_out.motion               <= motion_r;
      ctl_out.stop                 <= ~motion_r;
    end
  end

  // axi4-lite write side; address and data taken in either order
  logic        aw_full_r;
  logic        w_full_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic        wlane0_r;

  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire wr_go    = aw_full_r & w_full_r & ~s_axi_bvalid;
  wire wr_ctrl  = awaddr_r == REG_CTRL;
  wire wr_known = wr_ctrl | (awaddr_r == REG_STAT) | (awaddr_r == REG_MOTION);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r     <= 1'b0;
      w_full_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wlane0_r      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full_r     <= 1'b1;
        awaddr_r      <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_full_r     <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wlane0_r     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_full_r     <= 1'b0;
        w_full_r      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // start bit is a one-cycle pulse, it never reads back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seven_track_mode_r <= 1'b0;
      filemark_mode_r    <= 1'b0;
      write_active_r     <= 1'b0;
      start_r            <= 1'b0;
    end else begin
      start_r <= wr_go & wr_ctrl & wlane0_r & wdata_r[CTRL_START];
      if (wr_go && wr_ctrl && wlane0_r) begin
        seven_track_mode_r <= wdata_r[CTRL_SEVEN];
        filemark_mode_r    <= wdata_r[CTRL_FMK];
        write_active_r     <= wdata_r[CTRL_WRITE];
      end
    end
  end
  // axi4-lite read side
  wire [31:0] ctrl_word = {28'h0000000, 1'b0, write_active_r, filemark_mode_r,
                           seven_track_mode_r};
  wire [7:0]  stat_bits = {motion_r, decel_now, end_r, record_end_r, lrc_phase_r,
                           crc_phase_r, record_active, 1'b0};
  wire [31:0] stat_word = {16'h0000, gap_r, delay_r, strobe_cnt_r, stat_bits};
  wire [7:0]  rd_addr   = {s_axi_araddr[7:2], 2'b00};
  wire        rd_ctrl   = rd_addr == REG_CTRL;
  wire        rd_stat   = rd_addr == REG_STAT;
  wire        rd_motion = rd_addr == REG_MOTION;
  wire [31:0] rd_word   = rd_ctrl ? ctrl_word :
                          rd_stat ? stat_word :
                          rd_motion ? {16'h0000, motion_cnt_r} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= (rd_ctrl | rd_stat | rd_motion) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : tre_eor_detect

// *** bench/tre_drive_model.sv ***
`timescale 1ns/1ns
module tre_drive_model
  import tre_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic [6:0] lines,
  output tre_drv_in_type  drv
);
  logic char_pin;
  logic strobe_pin;
  logic slave_pin;
  // read lines stay a steady level through the stop load
  assign drv = {char_pin, strobe_pin, slave_pin, lines};
  initial begin
    char_pin = 1'h0;
    strobe_pin = 1'h0;
    slave_pin = 1'h0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge aclk);
  endtask : hold
  // one character time; pins kept 3 cycles each way for the synchronisers
  task automatic step(input logic s);
    if (s) begin
      strobe_pin <= 1'h1;
      hold(3);
      strobe_pin <= 1'h0;
      hold(3);
    end
    char_pin <= 1'h1;
    hold(3);
    char_pin <= 1'h0;
    hold(3);
  endtask : step
  // slave clock only runs on request, so no stray ticks reach the counter
  task automatic slave(input int n);
    repeat (n) begin
      slave_pin <= 1'h1;
      hold(2);
      slave_pin <= 1'h0;
      hold(4);
    end
  endtask : slave
endmodule : tre_drive_model

// *** bench/tre_eor_detect_sva.sv ***
`timescale 1ns/1ns
module tre_eor_detect_sva
  import tre_pkg::*;
(
  input wire logic           aclk,
  input wire logic           aresetn,
  input wire tre_drv_in_type drive_in,
  input wire tre_out_type    ctl_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_strobe_pair: assert property (
    ctl_out.read_data_strobe == ctl_out.check_register_pulse)
    else $error("data strobe and check pulse differ");
  a_crc_check_next: assert property (
    ctl_out.check_register_pulse && ctl_out.crc_next |=> ctl_out.lrc_next)
    else $error("check pulse in crc phase did not start lrc phase");
  a_lrc_check_clear: assert property (
    ctl_out.check_register_pulse && ctl_out.lrc_next |=> !ctl_out.lrc_next)
    else $error("check pulse in lrc phase left it set");
  a_phase_excl: assert property (ctl_out.lrc_next |-> !ctl_out.crc_next)
    else $error("both check phases shown");
  a_crc_err_phase: assert property (ctl_out.crc_error |-> ctl_out.crc_next)
    else $error("crc error outside crc phase");
  a_end_holds_crc: assert property (ctl_out.record_end |-> !ctl_out.crc_next)
    else $error("crc phase during record end");
  a_lrc_fall_end: assert property ($fell(ctl_out.lrc_next) |-> ##[0:1] ctl_out.record_end)
    else $error("record end missing after lrc phase");
  a_clear_in_end: assert property (ctl_out.read_clear_pulse |-> ctl_out.record_end)
    else $error("read clear without record end");
  a_clear_to_stop: assert property (
    ctl_out.read_clear_pulse |-> ##[0:1] ctl_out.stop_request)
    else $error("stop request late");
  a_load_drops_active: assert property (
    $rose(ctl_out.stop_request) |-> ##[0:2] !ctl_out.read_active)
    else $error("read active stays up after load");
  a_strobe_to_rds: assert property (
    $rose(drive_in.read_strobe) |-> ##[2:5] ctl_out.read_data_strobe)
    else $error("no data strobe for drive strobe");
  a_decel_stops: assert property (
    $rose(ctl_out.decel) |-> ##[0:1] (ctl_out.stop && !ctl_out.motion))
    else $error("decel did not stop motion");
  c_clear: cover property (ctl_out.read_clear_pulse);
  c_crc_err: cover property (ctl_out.crc_error);
  c_lrc_end: cover property ($fell(ctl_out.lrc_next));
endmodule : tre_eor_detect_sva

bind tre_eor_detect tre_eor_detect_sva tre_eor_detect_sva_inst (
  .aclk(aclk), .aresetn(aresetn), .drive_in(drive_in), .ctl_out(ctl_out));

// *** bench/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  import tre_pkg::*;
  logic           aclk, aresetn, crc_nonzero;
  logic [7:0]     awaddr, araddr;
  logic [31:0]    wdata, rdata;
  logic           awvalid, wvalid, bready, arvalid, rready;
  logic           awready, wready, bvalid, arready, rvalid;
  logic [1:0]     bresp, rresp;
  logic [6:0]     lines;
  tre_drv_in_type drive_in;
  tre_out_type    ctl_out;
  int             n_errors, comparisons, rds_seen, clr_seen;

  tre_eor_detect tre_eor_detect_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .drive_in(drive_in), .crc_nonzero(crc_nonzero), .ctl_out(ctl_out));
  tre_drive_model tre_drive_model_inst (.aclk(aclk), .lines(lines), .drv(drive_in));

  initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (ctl_out.read_data_strobe === 1'h1) rds_seen++;
    if (ctl_out.read_clear_pulse === 1'h1) clr_seen++;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    // an edge between transfers, so bready never toggles within one step
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!(bvalid && bready));
    bready <= 1'h0;
    chk("bresp", bresp, er);
  endtask : axi_wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!(rvalid && rready));
    rready <= 1'h0;
    chk("rdata", rdata, e);
    chk("rresp", rresp, er);
  endtask : rd_chk
  task automatic start_op(input logic [31:0] ctrl);
    axi_wr(REG_CTRL, ctrl | (32'h1 << CTRL_START), RESP_OKAY);
    repeat (4) @(posedge aclk);
    rds_seen = 0;
    clr_seen = 0;
    chk("motion", {ctl_out.motion, ctl_out.stop, ctl_out.decel}, 3'h4);
  endtask : start_op
  task automatic chars(input int n, input logic s);
    repeat (n) tre_drive_model_inst.step(s);
  endtask : chars
  task automatic ph(input logic [2:0] e);
    chk("phase", {ctl_out.crc_next, ctl_out.lrc_next, ctl_out.record_end}, e);
  endtask : ph
  // n counts character clocks still owed before the stop request
  task automatic wait_stop(input int n);
    chars(n - 1, 1'h0);
    chk("stop_early", ctl_out.stop_request, 1'h0);
    chars(1, 1'h0);
    repeat (8) @(posedge aclk);
    chk("stop_request", ctl_out.stop_request, 1'h1);
    chk("read_clear", clr_seen, 1);
  endtask : wait_stop

  task automatic t_regs();
    rd_chk(REG_MOTION, {16'h0, MOTION_RESET}, RESP_OKAY);
    chk("read_active", ctl_out.read_active, 1'h1);
    chk("idle_stop", {ctl_out.motion, ctl_out.stop, ctl_out.decel}, 3'h2);
    rd_chk(8'h0c, 32'h0, RESP_SLVERR);
    axi_wr(8'h0c, 32'hf, RESP_SLVERR);
    axi_wr(REG_CTRL, 32'hb, RESP_OKAY);
    rd_chk(REG_CTRL, 32'h3, RESP_OKAY);
  endtask : t_regs
  task automatic t_normal();
    start_op(32'h0);
    chars(4, 1'h1);
    crc_nonzero <= 1'h1;
    chars(1, 1'h0);
    ph(3'h0);
    chars(1, 1'h0);
    ph(3'h4);
    chk("crc_error", ctl_out.crc_error, 1'h1);
    crc_nonzero <= 1'h0;
    chars(1, 1'h1);
    ph(3'h2);
    chars(1, 1'h1);
    ph(3'h1);
    chk("rds_count", rds_seen, 6);
    wait_stop(7);
    chk("read_active", ctl_out.read_active, 1'h0);
    rd_chk(REG_MOTION, 32'he055, RESP_OKAY);
    tre_drive_model_inst.slave(1);
    rd_chk(REG_MOTION, 32'he055, RESP_OKAY);
    tre_drive_model_inst.slave(1);
    rd_chk(REG_MOTION, 32'he056, RESP_OKAY);
    tre_drive_model_inst.slave(4);
    rd_chk(REG_MOTION, 32'he057, RESP_OKAY);
  endtask : t_normal
  task automatic t_gated();
    start_op(32'h4);
    chars(4, 1'h1);
    chars(10, 1'h0);
    ph(3'h0);
    start_op(32'h0);
    chars(2, 1'h1);
    chars(5, 1'h0);
    ph(3'h0);
    chars(1, 1'h1);
    chars(2, 1'h0);
    ph(3'h4);
  endtask : t_gated
  task automatic t_zero_lrc();
    start_op(32'h0);
    ph(3'h0);
    chars(4, 1'h1);
    chars(2, 1'h0);
    chars(1, 1'h1);
    chars(4, 1'h0);
    ph(3'h2);
    chars(1, 1'h0);
    ph(3'h1);
    wait_stop(24);
  endtask : t_zero_lrc
  task automatic t_seven();
    start_op(32'h1);
    chars(4, 1'h1);
    chars(2, 1'h0);
    ph(3'h2);
    chars(1, 1'h1);
    ph(3'h1);
    wait_stop(7);
  endtask : t_seven
  task automatic t_filemark();
    start_op(32'h2);
    chars(1, 1'h1);
    chars(2, 1'h0);
    ph(3'h2);
    chars(3, 1'h0);
    ph(3'h1);
    wait_stop(24);
  endtask : t_filemark
  task automatic t_restart();
    start_op(32'h0);
    chars(4, 1'h1);
    chars(2, 1'h0);
    chars(2, 1'h1);
    chars(3, 1'h0);
    chars(1, 1'h1);
    chars(2, 1'h0);
    ph(3'h1);
    wait_stop(21);
  endtask : t_restart

  task automatic stop_test();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // whole run is under two thousand cycles; the 20000-cycle limit leaves ample margin
  initial begin
    #400000;
    n_errors++;
    stop_test();
  end
  initial begin
    aresetn = 1'h0;
    crc_nonzero = 1'h0;
    lines = 7'h55;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    awvalid = 1'h0;
    wvalid = 1'h0;
    bready = 1'h0;
    arvalid = 1'h0;
    rready = 1'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_regs();
    t_normal();
    t_gated();
    t_zero_lrc();
    t_seven();
    t_filemark();
    t_restart();
    stop_test();
  end
endmodule : testbench
